// >>> status_word_bank_select.sv
// Status word flags, bank selector and register-set remapping of the core.
// Assumes one core clock, a synchronous reset and Wishbone classic registers.
// Operation
// - Interrupt enable clear: only non-maskable and unmasked macro requests accepted.
// - Interrupt enable set: maskable acceptance follows own mask and priority.
// - Enable instruction sets the flag; disable instruction or acknowledge clears it.
// - Aux carry follows carry out of or borrow into bit 3.
// - Decimal adjust after add or subtract uses aux carry as input.
// - Zero flag set when result is zero; offered to branches.
// - Sign flag copies result MSB; offered to branches.
// - Three-bit bank field selects one of eight banks in binary.
// - Select-bank instruction stores bank number into the bank field.
// - User flag changes only by program writes.
// - Remap applies to named, implied and index or base register uses.
// - Standard set maps A,X,B,C to 1,0,3,2; alternate to 5,4,7,6.
// - Other register references ignore the register-set bit.
// - Register-set bit is low byte bit 5, bit set and clear reach it.
// - Sixteen-bit word, accessed as high and low byte and per flag.
// - Reset clears the whole word.
// - Word pushed on vectored interrupt or break, restored on return.
module status_word_bank_select
    import psw_pkg::*;
#(
    parameter int N_IRQ = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Instruction strobes
    input wire logic ei_instr_i,
    input wire logic di_instr_i,
    input wire logic sel_bank_i,
    input wire logic [2:0] sel_bank_num_i,
    input wire logic bit_op_i,
    input wire logic bit_set_i,
    input wire logic bit_high_i,
    input wire logic [2:0] bit_pos_i,
    input wire logic byte_we_i,
    input wire logic byte_high_i,
    input wire logic [7:0] byte_data_i,
    // Arithmetic results
    input wire logic sz_we_i,
    input wire logic wide_i,
    input wire logic [15:0] result_i,
    input wire logic ac_we_i,
    input wire logic sub_i,
    input wire logic [3:0] nib_a_i,
    input wire logic [3:0] nib_b_i,
    // Decimal adjust
    input wire logic dec_adj_i,
    input wire logic dec_sub_i,
    input wire logic [7:0] dec_val_i,
    output logic [7:0] dec_result_o,
    output logic dec_valid_o,
    // Save and restore
    input wire logic save_i,
    input wire logic restore_i,
    input wire logic [15:0] restore_data_i,
    output logic [15:0] saved_word_o,
    // Interrupt acceptance
    input wire logic nmi_req_i,
    input wire logic macro_req_i,
    input wire logic macro_mask_i,
    input wire logic [N_IRQ-1:0] irq_req_i,
    input wire logic [N_IRQ-1:0] irq_mask_i,
    input wire logic [N_IRQ-1:0] irq_high_prio_i,
    input wire logic int_ack_i,
    output logic nmi_accept_o,
    output logic macro_accept_o,
    output logic [N_IRQ-1:0] irq_grant_o,
    // Register remapping
    input wire logic [1:0] ref_kind_i,
    input wire logic [1:0] lreg_i,
    input wire logic [3:0] abs_reg_i,
    output logic [3:0] phys_reg_o,
    output logic [2:0] phys_bank_o,
    // Status view
    output logic [15:0] status_o,
    output logic zero_o,
    output logic sign_o
);
    import psw_pkg::*;

    if (N_IRQ < 1 || N_IRQ > 32) begin : g_bad_nirq
        $error("N_IRQ out of range");
    end

    function automatic logic [N_IRQ-1:0] first_set(input logic [N_IRQ-1:0] v);
        logic [N_IRQ-1:0] r;
        r = '0;
        for (int i = N_IRQ - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = '0;
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction

    function automatic logic aux_carry(input logic [3:0] a, input logic [3:0] b,
                                       input logic sub);
        logic [4:0] s;
        s = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
        return s[4];
    endfunction

    function automatic logic [7:0] dec_adjust(input logic [7:0] v, input logic cy,
                                              input logic ac, input logic sub);
        logic [7:0] corr;
        corr = 8'h00;
        if (ac || v[3:0] > 4'h9) begin
            corr[3:0] = 4'h6;
        end
        if (cy || v > 8'h99) begin
            corr[7:4] = 4'h6;
        end
        return sub ? v - corr : v + corr;
    endfunction

    logic [7:0] low_r, low_nxt;
    logic [7:0] high_r, high_nxt;
    logic [15:0] saved_r, saved_nxt;
    logic [7:0] dec_r, dec_nxt;
    logic dec_valid_r, dec_valid_nxt;
    logic [3:0] phys_r, phys_nxt;
    logic [2:0] pbank_r, pbank_nxt;
    logic ack_r, ack_nxt;
    logic [31:0] rdat_r, rdat_nxt;
    logic wb_req, wb_wr;
    logic [N_IRQ-1:0] open_req, hi_req;

    assign wb_req = wb_cyc_i && wb_stb_i;
    assign wb_wr = wb_req && wb_we_i && ack_r && wb_sel_i[0];

    // Status word update, lowest priority applied first
    always_comb begin
        low_nxt = low_r;
        high_nxt = high_r;
        if (sz_we_i) begin
            low_nxt[BIT_ZERO] = wide_i ? (result_i == 16'h0000)
                                       : (result_i[7:0] == 8'h00);
            low_nxt[BIT_SIGN] = wide_i ? result_i[15] : result_i[7];
        end
        if (ac_we_i) begin
            low_nxt[BIT_AUX_CARRY] = aux_carry(nib_a_i, nib_b_i, sub_i);
        end
        if (ei_instr_i) begin
            low_nxt[BIT_INT_ENABLE] = 1'b1;
        end
        if (di_instr_i || int_ack_i) begin
            low_nxt[BIT_INT_ENABLE] = 1'b0;
        end
        if (sel_bank_i) begin
            high_nxt[BIT_BANK_HIGH:BIT_BANK_LOW] = sel_bank_num_i;
        end
        if (bit_op_i) begin
            if (bit_high_i) begin
                high_nxt[bit_pos_i] = HIGH_WMASK[bit_pos_i] ? bit_set_i : 1'b0;
            end else begin
                low_nxt[bit_pos_i] = LOW_WMASK[bit_pos_i] ? bit_set_i : 1'b0;
            end
        end
        if (byte_we_i) begin
            if (byte_high_i) begin
                high_nxt = byte_data_i & HIGH_WMASK;
            end else begin
                low_nxt = byte_data_i & LOW_WMASK;
            end
        end
        if (wb_wr && wb_adr_i == OFS_STATUS_LOW) begin
            low_nxt = wb_dat_i[7:0] & LOW_WMASK;
        end
        if (wb_wr && wb_adr_i == OFS_STATUS_HIGH) begin
            high_nxt = wb_dat_i[7:0] & HIGH_WMASK;
        end
        if (restore_i) begin
            low_nxt = restore_data_i[7:0] & LOW_WMASK;
            high_nxt = restore_data_i[15:8] & HIGH_WMASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_r <= PSW_RESET[7:0];
            high_r <= PSW_RESET[15:8];
        end else begin
            low_r <= low_nxt;
            high_r <= high_nxt;
        end
    end

    // Save slot, decimal adjust and remap results
    always_comb begin
        saved_nxt = save_i ? {high_r, low_r} : saved_r;
        dec_valid_nxt = dec_adj_i;
        dec_nxt = dec_adj_i ? dec_adjust(dec_val_i, low_r[BIT_CARRY], low_r[BIT_AUX_CARRY],
                                         dec_sub_i) : dec_r;
        pbank_nxt = high_r[BIT_BANK_HIGH:BIT_BANK_LOW];
        case (ref_kind_i)
            REF_NAMED, REF_IMPLIED, REF_INDEXED: begin
                // Logical codes equal the standard-set register numbers
                phys_nxt = {2'b00, lreg_i} +
                           (low_r[BIT_REG_SET] ? ALT_SET_OFS : 4'h0);
            end
            default: phys_nxt = abs_reg_i;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            saved_r <= PSW_RESET;
            dec_r <= 8'h00;
            dec_valid_r <= 1'b0;
            phys_r <= 4'h0;
            pbank_r <= 3'h0;
        end else begin
            saved_r <= saved_nxt;
            dec_r <= dec_nxt;
            dec_valid_r <= dec_valid_nxt;
            phys_r <= phys_nxt;
            pbank_r <= pbank_nxt;
        end
    end

    // Interrupt acceptance
    always_comb begin
        open_req = irq_req_i & ~irq_mask_i;
        hi_req = open_req & irq_high_prio_i;
        nmi_accept_o = nmi_req_i;
        macro_accept_o = macro_req_i && !macro_mask_i;
        irq_grant_o = '0;
        if (low_r[BIT_INT_ENABLE] && !nmi_req_i) begin
            irq_grant_o = first_set((hi_req != '0) ? hi_req : open_req);
        end
    end

    // Wishbone slave: ack one cycle after the request
    always_comb begin
        ack_nxt = wb_req && !ack_r;
        rdat_nxt = rdat_r;
        if (wb_req && !ack_r) begin
            case (wb_adr_i)
                OFS_STATUS_LOW: rdat_nxt = {24'h000000, low_r};
                OFS_STATUS_HIGH: rdat_nxt = {24'h000000, high_r};
                OFS_STATUS_WORD: rdat_nxt = {16'h0000, high_r, low_r};
                OFS_MAP_VIEW: rdat_nxt = {25'h0000000, pbank_r, phys_r};
                default: rdat_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            rdat_r <= 32'h00000000;
        end else begin
            ack_r <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;
    assign status_o = {high_r, low_r};
    assign zero_o = low_r[BIT_ZERO];
    assign sign_o = low_r[BIT_SIGN];
    assign saved_word_o = saved_r;
    assign dec_result_o = dec_r;
    assign dec_valid_o = dec_valid_r;
    assign phys_reg_o = phys_r;
    assign phys_bank_o = pbank_r;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_quiet;
        !byte_we_i && !bit_op_i && !restore_i && !wb_wr;
    endsequence

    sequence s_ei_only;
        (ei_instr_i && !di_instr_i && !int_ack_i) and s_quiet;
    endsequence

    a_ie_gate: assert property (!low_r[BIT_INT_ENABLE] |-> irq_grant_o == '0)
        else $error("maskable grant while interrupts disabled");
    a_grant_unmasked: assert property ((irq_grant_o & (irq_mask_i | ~irq_req_i)) == '0)
        else $error("grant to masked or idle request");
    a_grant_given: assert property (low_r[BIT_INT_ENABLE] && !nmi_req_i
        && (irq_req_i & ~irq_mask_i) != '0 |-> $onehot(irq_grant_o))
        else $error("open request not granted");
    a_ei_sets: assert property (s_ei_only |=> low_r[BIT_INT_ENABLE])
        else $error("enable instruction missed");
    a_ack_clears: assert property ((int_ack_i and s_quiet) |=> !low_r[BIT_INT_ENABLE])
        else $error("acknowledge did not clear enable");
    a_aux_carry: assert property ((ac_we_i and s_quiet) |=>
        low_r[BIT_AUX_CARRY] == $past(aux_carry(nib_a_i, nib_b_i, sub_i)))
        else $error("aux carry wrong");
    a_zero_flag: assert property (((sz_we_i && !wide_i) and s_quiet) |=>
        zero_o == ($past(result_i[7:0]) == 8'h00))
        else $error("zero flag wrong");
    a_sign_flag: assert property (((sz_we_i && wide_i) and s_quiet) |=>
        sign_o == $past(result_i[15]))
        else $error("sign flag wrong");
    a_bank_sel: assert property ((sel_bank_i and s_quiet) |=> ##1
        phys_bank_o == $past(sel_bank_num_i, 2))
        else $error("bank select not applied");
    a_flags_hold: assert property (((!sz_we_i && !ac_we_i) and s_quiet) |=>
        $stable(low_r[BIT_SIGN]) && $stable(low_r[BIT_AUX_CARRY]))
        else $error("arithmetic flag changed without cause");
    a_remap_alt: assert property (ref_kind_i != REF_ABSOLUTE && low_r[BIT_REG_SET]
        |=> phys_reg_o[2])
        else $error("alternate set not used");
    a_abs_fixed: assert property (ref_kind_i == REF_ABSOLUTE |=>
        phys_reg_o == $past(abs_reg_i))
        else $error("absolute register remapped");
    a_restore_word: assert property (restore_i |=>
        status_o == ($past(restore_data_i) & {HIGH_WMASK, LOW_WMASK}))
        else $error("restore did not load word");
    a_wb_ack: assert property (wb_req && !ack_r |=> ack_r ##1 !ack_r)
        else $error("ack not a single pulse");
endmodule

// >>> psw_pkg.sv
// Package for the status word and bank select block.
// Assumes a 32-bit classic Wishbone register bus and a 200 MHz core clock.
package psw_pkg;
    // Register byte addresses
    localparam logic [3:0] OFS_STATUS_LOW = 4'h0;
    localparam logic [3:0] OFS_STATUS_HIGH = 4'h4;
    localparam logic [3:0] OFS_STATUS_WORD = 4'h8;
    localparam logic [3:0] OFS_MAP_VIEW = 4'hc;
    // Low byte field positions
    localparam int BIT_CARRY = 0;
    localparam int BIT_ZERO_CONST = 1;
    localparam int BIT_PARITY_OVF = 2;
    localparam int BIT_INT_ENABLE = 3;
    localparam int BIT_AUX_CARRY = 4;
    localparam int BIT_REG_SET = 5;
    localparam int BIT_ZERO = 6;
    localparam int BIT_SIGN = 7;
    // High byte field positions
    localparam int BIT_BANK_LOW = 4;
    localparam int BIT_BANK_HIGH = 6;
    localparam int BIT_USER = 7;
    // Writable bit masks and reset value
    localparam logic [7:0] LOW_WMASK = 8'hfd;
    localparam logic [7:0] HIGH_WMASK = 8'hf0;
    localparam logic [15:0] PSW_RESET = 16'h0000;
    // Logical register codes for remapping
    localparam logic [1:0] LREG_X = 2'h0;
    localparam logic [1:0] LREG_A = 2'h1;
    localparam logic [1:0] LREG_C = 2'h2;
    localparam logic [1:0] LREG_B = 2'h3;
    // Offset added to a logical register under the alternate set
    localparam logic [3:0] ALT_SET_OFS = 4'h4;
    // Reference classes for a register access
    typedef enum logic [1:0] {
        REF_ABSOLUTE,
        REF_NAMED,
        REF_IMPLIED,
        REF_INDEXED
    } ref_kind_e;
endpackage

// >>> status_word_bank_select_tb.sv
// Self-checking bench for the status word and bank select block.
// Assumes the block's package is compiled first; drives every port itself.
module status_word_bank_select_tb
    import psw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0;
    logic [3:0] wb_adr_i = '0, wb_sel_i = '0, abs_reg_i = '0, nib_a_i = '0, nib_b_i = '0;
    logic [31:0] wb_dat_i = '0;
    logic ei_instr_i = '0, di_instr_i = '0, sel_bank_i = '0, bit_op_i = '0, bit_set_i = '0;
    logic bit_high_i = '0, byte_we_i = '0, byte_high_i = '0, sz_we_i = '0, wide_i = '0;
    logic ac_we_i = '0, sub_i = '0, dec_adj_i = '0, dec_sub_i = '0, save_i = '0;
    logic restore_i = '0, nmi_req_i = '0, macro_req_i = '0, macro_mask_i = '0, int_ack_i = '0;
    logic [2:0] sel_bank_num_i = '0, bit_pos_i = '0;
    logic [7:0] byte_data_i = '0, dec_val_i = '0, irq_req_i = '0, irq_mask_i = '0;
    logic [7:0] irq_high_prio_i = '0;
    logic [15:0] result_i = '0, restore_data_i = '0;
    logic [1:0] ref_kind_i = '0, lreg_i = '0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, dec_valid_o, nmi_accept_o, macro_accept_o, zero_o, sign_o;
    logic [7:0] dec_result_o, irq_grant_o;
    logic [15:0] saved_word_o, status_o;
    logic [3:0] phys_reg_o;
    logic [2:0] phys_bank_o;
    int miscompares = 0, cmp_count = 0, cyc_n = 0;

    status_word_bank_select #(.N_IRQ(8)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ei_instr_i(ei_instr_i),
        .di_instr_i(di_instr_i), .sel_bank_i(sel_bank_i), .sel_bank_num_i(sel_bank_num_i),
        .bit_op_i(bit_op_i), .bit_set_i(bit_set_i), .bit_high_i(bit_high_i),
        .bit_pos_i(bit_pos_i), .byte_we_i(byte_we_i), .byte_high_i(byte_high_i),
        .byte_data_i(byte_data_i), .sz_we_i(sz_we_i), .wide_i(wide_i), .result_i(result_i),
        .ac_we_i(ac_we_i), .sub_i(sub_i), .nib_a_i(nib_a_i), .nib_b_i(nib_b_i),
        .dec_adj_i(dec_adj_i), .dec_sub_i(dec_sub_i), .dec_val_i(dec_val_i),
        .dec_result_o(dec_result_o), .dec_valid_o(dec_valid_o), .save_i(save_i),
        .restore_i(restore_i), .restore_data_i(restore_data_i), .saved_word_o(saved_word_o),
        .nmi_req_i(nmi_req_i), .macro_req_i(macro_req_i), .macro_mask_i(macro_mask_i),
        .irq_req_i(irq_req_i), .irq_mask_i(irq_mask_i), .irq_high_prio_i(irq_high_prio_i),
        .int_ack_i(int_ack_i), .nmi_accept_o(nmi_accept_o), .macro_accept_o(macro_accept_o),
        .irq_grant_o(irq_grant_o), .ref_kind_i(ref_kind_i), .lreg_i(lreg_i),
        .abs_reg_i(abs_reg_i), .phys_reg_o(phys_reg_o), .phys_bank_o(phys_bank_o),
        .status_o(status_o), .zero_o(zero_o), .sign_o(sign_o)
    );

    always #2.5 clk_i = ~clk_i;

    // Hang guard, far above the roughly 170 cycles the run needs
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 3000) begin
            miscompares++;
            print_verdict();
        end
    end

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Classic single cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [3:0] a, input logic [3:0] s,
                      input logic [7:0] d, output logic [31:0] q);
        int n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        chk("wb_ack_o", 32'h1, wb_ack_o);
    endtask

    // One-cycle strobe on a status input, checked once it has landed
    task automatic ac(input logic [3:0] a, input logic [3:0] b, input logic s, input logic e);
        tick(1);
        ac_we_i <= 1'b1;
        nib_a_i <= a;
        nib_b_i <= b;
        sub_i <= s;
        tick(1);
        ac_we_i <= 1'b0;
        #1;
        chk("aux carry", e, status_o[BIT_AUX_CARRY]);
    endtask

    task automatic sz(input logic [15:0] r, input logic w, input logic z, input logic s);
        tick(1);
        sz_we_i <= 1'b1;
        result_i <= r;
        wide_i <= w;
        tick(1);
        sz_we_i <= 1'b0;
        #1;
        chk("zero_o", z, zero_o);
        chk("sign_o", s, sign_o);
    endtask

    task automatic bit_op(input logic s, input logic h, input logic [2:0] p);
        tick(1);
        bit_op_i <= 1'b1;
        bit_set_i <= s;
        bit_high_i <= h;
        bit_pos_i <= p;
        tick(1);
        bit_op_i <= 1'b0;
        #1;
    endtask

    task automatic dec(input logic s, input logic [7:0] v, input logic [7:0] e);
        tick(1);
        dec_adj_i <= 1'b1;
        dec_sub_i <= s;
        dec_val_i <= v;
        tick(1);
        dec_adj_i <= 1'b0;
        #1;
        chk("dec_valid_o", 32'h1, dec_valid_o);
        chk("dec_result_o", e, dec_result_o);
    endtask

    task automatic t_int;
        tick(1);
        irq_req_i <= 8'h06;
        irq_high_prio_i <= 8'h04;
        macro_req_i <= 1'b1;
        macro_mask_i <= 1'b1;
        nmi_req_i <= 1'b1;
        #1;
        chk("grant ie0", 32'h0, irq_grant_o);
        chk("nmi accept", 32'h1, nmi_accept_o);
        chk("macro masked", 32'h0, macro_accept_o);
        tick(1);
        macro_mask_i <= 1'b0;
        nmi_req_i <= 1'b0;
        ei_instr_i <= 1'b1;
        tick(1);
        ei_instr_i <= 1'b0;
        #1;
        chk("macro accept", 32'h1, macro_accept_o);
        chk("ie set", 32'h1, status_o[BIT_INT_ENABLE]);
        chk("grant prio", 32'h4, irq_grant_o);
        tick(1);
        irq_mask_i <= 8'h04;
        int_ack_i <= 1'b1;
        #1;
        chk("grant mask", 32'h2, irq_grant_o);
        tick(1);
        int_ack_i <= 1'b0;
        ei_instr_i <= 1'b1;
        #1;
        chk("ie ack", 32'h0, status_o[BIT_INT_ENABLE]);
        tick(1);
        ei_instr_i <= 1'b0;
        di_instr_i <= 1'b1;
        tick(1);
        di_instr_i <= 1'b0;
        #1;
        chk("ie di", 32'h0, status_o[BIT_INT_ENABLE]);
        $display("test interrupts done");
    endtask

    task automatic t_flags;
        ac(4'h8, 4'h8, 1'b0, 1'b1);
        ac(4'h7, 4'h8, 1'b0, 1'b0);
        ac(4'h0, 4'h1, 1'b1, 1'b1);
        ac(4'h9, 4'h1, 1'b1, 1'b0);
        sz(16'hff00, 1'b0, 1'b1, 1'b0);
        sz(16'h0080, 1'b0, 1'b0, 1'b1);
        sz(16'h8000, 1'b1, 1'b0, 1'b1);
        tick(1);
        byte_we_i <= 1'b1;
        byte_high_i <= 1'b1;
        byte_data_i <= 8'h80;
        tick(1);
        byte_we_i <= 1'b0;
        #1;
        chk("user set", 32'h1, status_o[8 + BIT_USER]);
        sz(16'h0000, 1'b1, 1'b1, 1'b0);
        ac(4'h8, 4'h8, 1'b0, 1'b1);
        chk("zero kept", 32'h1, zero_o);
        chk("user kept", 32'h1, status_o[8 + BIT_USER]);
        bit_op(1'b0, 1'b1, 3'h7);
        chk("user clear", 32'h0, status_o[8 + BIT_USER]);
        dec(1'b0, 8'h01, 8'h07);
        ac(4'h0, 4'h1, 1'b1, 1'b1);
        dec(1'b1, 8'h18, 8'h12);
        ac(4'h7, 4'h8, 1'b0, 1'b0);
        dec(1'b0, 8'h01, 8'h01);
        $display("test flags done");
    endtask

    task automatic t_bank;
        for (int i = 0; i < 8; i++) begin
            tick(1);
            sel_bank_i <= 1'b1;
            sel_bank_num_i <= i[2:0];
            tick(1);
            sel_bank_i <= 1'b0;
            #1;
            chk("bank field", i, status_o[14:12]);
            tick(1);
            #1;
            chk("phys bank", i, phys_bank_o);
        end
        for (int r = 1; r >= 0; r--) begin
            bit_op(r[0], 1'b0, 3'h5);
            chk("reg set bit", r, status_o[BIT_REG_SET]);
            for (int k = 0; k < 16; k++) begin
                tick(1);
                ref_kind_i <= k[3:2];
                lreg_i <= k[1:0];
                abs_reg_i <= 4'h9;
                tick(1);
                #1;
                chk("phys reg", (k < 4) ? 9 : k % 4 + 4 * r, phys_reg_o);
            end
        end
        $display("test banks done");
    endtask

    task automatic t_wb;
        logic [31:0] q;
        wb(1'b1, OFS_STATUS_LOW, 4'h1, 8'hff, q);
        wb(1'b1, OFS_STATUS_HIGH, 4'h1, 8'hff, q);
        wb(1'b1, OFS_STATUS_LOW, 4'h0, 8'h00, q);
        wb(1'b1, OFS_STATUS_WORD, 4'h1, 8'h00, q);
        wb(1'b0, OFS_STATUS_LOW, 4'h1, 8'h00, q);
        chk("low byte", 32'hfd, q);
        wb(1'b0, OFS_STATUS_HIGH, 4'h1, 8'h00, q);
        chk("high byte", 32'hf0, q);
        wb(1'b0, OFS_STATUS_WORD, 4'h1, 8'h00, q);
        chk("word", 32'hf0fd, q);
        wb(1'b0, 4'h2, 4'h1, 8'h00, q);
        chk("unmapped", 32'h0, q);
        // Bank 7 and alternate set now selected; remap inputs still index B
        wb(1'b0, OFS_MAP_VIEW, 4'h1, 8'h00, q);
        chk("map view", 32'h77, q);
        tick(1);
        save_i <= 1'b1;
        tick(1);
        save_i <= 1'b0;
        restore_i <= 1'b1;
        restore_data_i <= 16'h1234;
        tick(1);
        restore_i <= 1'b0;
        #1;
        chk("saved word", 32'hf0fd, saved_word_o);
        chk("restored", 32'h1034, status_o);
        $display("test registers done");
    endtask

    initial begin
        logic [31:0] q;
        tick(4);
        rst_i <= 1'b0;
        tick(1);
        #1;
        chk("reset status", 32'h0, status_o);
        wb(1'b0, OFS_STATUS_WORD, 4'h1, 8'h00, q);
        chk("reset word", 32'h0, q);
        $display("test reset done");
        t_int();
        t_flags();
        t_bank();
        t_wb();
        print_verdict();
    end
endmodule
